// ---- pkg/tcb_consts.svh ----
/*
 * Constants for the tag configuration byte bank: byte indices, bit positions,
 * reset values and protocol figures.
 * Assumes it is included by its bare name from every file that needs it.
 */
`ifndef TCB_CONSTS_SVH
`define TCB_CONSTS_SVH

`define TCB_NBYTES 7
`define TCB_IDX_ANS 3'h0
`define TCB_IDX_SEL 3'h1
`define TCB_IDX_CFG0 3'h2
`define TCB_IDX_CFG1 3'h3
`define TCB_IDX_CFG2 3'h4
`define TCB_IDX_MASK0 3'h5
`define TCB_IDX_MASK1 3'h6
`define TCB_WORKING_ONLY 3

`define TCB_ANS_DEF 8'h44
`define TCB_SEL_DEF 8'h00
`define TCB_CFG0_DEF 8'h00
`define TCB_CFG1_DEF 8'h00
`define TCB_CFG2_DEF 8'h80
`define TCB_MASK_DEF 8'h00

`define TCB_B_SILENT_EN 7
`define TCB_B_THR_HI 6
`define TCB_B_THR_LO 4
`define TCB_B_ARB 3
`define TCB_B_ADDR_HI 2
`define TCB_B_CRC_STORE 7
`define TCB_B_VREG_HI 6
`define TCB_B_VREG_LO 2
`define TCB_B_RRES_HI 1
`define TCB_B_RFCFG_EN 7
`define TCB_B_TUN 6
`define TCB_B_EXT 5
`define TCB_B_NAK 4
`define TCB_B_AUTH_SET 3
`define TCB_B_SEL_INV 2
`define TCB_B_POW_HI 1
`define TCB_B_CASCADE 2
`define TCB_B_SEL6 6

`define TCB_I2C_GROUP 4'hA
`define TCB_PAYLOAD_CRC 6'h1E
`define TCB_PAYLOAD_FULL 6'h20

`define TCB_HA_CTRL 8'h00
`define TCB_HA_STATUS 8'h04
`define TCB_HA_TARGET 8'h08

`endif

// ---- pkg/tcb_pkg.sv ----
/*
 * Types shared by both ends of the configuration byte bank link.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tcb_pkg;
    typedef enum logic [1:0] {
        TCB_MODE_STANDALONE = 2'b00,
        TCB_MODE_TUNNEL = 2'b01,
        TCB_MODE_EXTENDED = 2'b10
    } tcb_mode_e;

    typedef enum logic [1:0] {
        TCB_RF_CONFIG = 2'b00,
        TCB_RF_AUTH_SETTING = 2'b01,
        TCB_RF_PASSWORD = 2'b10
    } tcb_rf_kind_e;

    typedef logic [7:0] tcb_byte_t;
endpackage

// ---- pkg/tcb_link_if.sv ----
/*
 * Serial-host link between the host controller and the tag, reduced to one
 * addressed byte transfer at a time.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface tcb_link_if;
    logic req;
    logic we;
    logic [6:0] dev_addr;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic ack;
    logic nack;
    logic [7:0] rdata;

    modport host (output req, output we, output dev_addr, output addr, output wdata,
                  input ack, input nack, input rdata);
    modport device (input req, input we, input dev_addr, input addr, input wdata,
                    output ack, output nack, output rdata);
endinterface

// ---- rtl/tcb_arbiter.sv ----
/*
 * Memory access arbiter between the RF side and the serial host side.
 * Assumes each requester holds its request until it has finished.
 */
`timescale 1ns/1ps
module tcb_arbiter (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic rf_priority,
    input wire logic rf_req,
    input wire logic host_req,
    output logic rf_grant,
    output logic host_grant
);
    logic rf_grant_next;
    logic host_grant_next;

    // A tie in one cycle goes to RF, since RF timing cannot be stretched.
    always_comb begin
        rf_grant_next = 1'b0;
        host_grant_next = 1'b0;
        if (rf_priority) begin
            rf_grant_next = rf_req;
            host_grant_next = host_req && !rf_req;
        end else if (rf_grant && rf_req) begin
            rf_grant_next = 1'b1;
        end else if (host_grant && host_req) begin
            host_grant_next = 1'b1;
        end else begin
            rf_grant_next = rf_req;
            host_grant_next = host_req && !rf_req;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rf_grant <= 1'b0;
            host_grant <= 1'b0;
        end else begin
            rf_grant <= rf_grant_next;
            host_grant <= host_grant_next;
        end
    end
endmodule

// ---- rtl/tcb_device.sv ----
/*
 * Tag end: configuration byte bank with stored and working copies, RF access
 * control, anticollision answers, silent mode and mode selection.
 * Assumes a host on the link interface and RF, field and comparator inputs
 * synchronous to hclk.
 */
`timescale 1ns/1ps
`include "tcb_consts.svh"
module tcb_device (
    input wire logic hclk,
    input wire logic hresetn,
    tcb_link_if.device link,
    input wire logic rf_req,
    input wire tcb_pkg::tcb_rf_kind_e rf_kind,
    input wire logic rf_we,
    input wire logic [2:0] rf_addr,
    input wire logic [7:0] rf_wdata,
    input wire logic rf_authenticated,
    input wire logic cascade_level2,
    input wire logic field_present,
    input wire logic supply_below,
    input wire logic rf_mem_req,
    input wire logic host_mem_req,
    output logic rf_ack,
    output logic rf_refused,
    output logic [7:0] rf_rdata,
    output logic rf_auth_write_ok,
    output logic [7:0] sens_res_byte1,
    output logic [7:0] sel_res,
    output logic rf_off,
    output logic [2:0] silent_threshold_code,
    output logic [6:0] i2c_address,
    output logic crc_store,
    output logic crc_check_en,
    output logic [5:0] payload_limit,
    output logic [4:0] aux_regulator_level,
    output logic [1:0] aux_regulator_res,
    output tcb_pkg::tcb_mode_e mode,
    output logic route_to_memory,
    output logic nak_on_error,
    output logic [1:0] power_mode,
    output logic [7:0] irq_mask_0,
    output logic [7:0] irq_mask_1,
    output logic rf_mem_grant,
    output logic host_mem_grant
);
    import tcb_pkg::*;

    tcb_byte_t cfg_nv_reg [`TCB_NBYTES];
    tcb_byte_t cfg_wk_reg [`TCB_NBYTES];
    logic loaded_reg;
    logic answered_reg;
    logic field_prev_reg;
    logic below_latched_reg;
    logic host_take;
    logic host_match;
    logic host_wr;
    logic host_wk_only;
    logic rf_ok;
    logic rf_wr;
    logic [7:0] sel_next;
    tcb_mode_e mode_next;

    assign host_match = (link.dev_addr ==
        {`TCB_I2C_GROUP, cfg_wk_reg[`TCB_IDX_CFG0][`TCB_B_ADDR_HI:0]});
    assign host_take = link.req && !answered_reg && loaded_reg;
    assign host_wr = host_take && host_match && link.we;
    assign host_wk_only = link.addr[`TCB_WORKING_ONLY];
    // RF requests are refused while the RF part is off or still loading.
    always_comb begin
        rf_ok = 1'b0;
        unique case (rf_kind)
            TCB_RF_CONFIG: rf_ok = cfg_wk_reg[`TCB_IDX_CFG2][`TCB_B_RFCFG_EN];
            TCB_RF_AUTH_SETTING:
                rf_ok = cfg_wk_reg[`TCB_IDX_CFG2][`TCB_B_AUTH_SET] && rf_authenticated;
            TCB_RF_PASSWORD: rf_ok = rf_authenticated;
            default: rf_ok = 1'b0;
        endcase
        if (rf_off || !loaded_reg) begin
            rf_ok = 1'b0;
        end
    end
    assign rf_wr = rf_req && rf_ok && rf_we && (rf_kind == TCB_RF_CONFIG)
        && (rf_addr < `TCB_NBYTES);

    // Stored copy: written by the host and by permitted RF writes. Host is last so it wins.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_nv_reg[`TCB_IDX_ANS] <= `TCB_ANS_DEF;
            cfg_nv_reg[`TCB_IDX_SEL] <= `TCB_SEL_DEF;
            cfg_nv_reg[`TCB_IDX_CFG0] <= `TCB_CFG0_DEF;
            cfg_nv_reg[`TCB_IDX_CFG1] <= `TCB_CFG1_DEF;
            cfg_nv_reg[`TCB_IDX_CFG2] <= `TCB_CFG2_DEF;
            cfg_nv_reg[`TCB_IDX_MASK0] <= `TCB_MASK_DEF;
            cfg_nv_reg[`TCB_IDX_MASK1] <= `TCB_MASK_DEF;
        end else begin
            if (rf_wr) begin
                cfg_nv_reg[rf_addr] <= rf_wdata;
            end
            if (host_wr && !host_wk_only && (link.addr[2:0] < `TCB_NBYTES)) begin
                cfg_nv_reg[link.addr[2:0]] <= link.wdata;
            end
        end
    end

    // Working copy: filled from the stored copy once after reset, then follows writes.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < `TCB_NBYTES; i++) begin
                cfg_wk_reg[i] <= 8'h00;
            end
            loaded_reg <= 1'b0;
        end else if (!loaded_reg) begin
            for (int i = 0; i < `TCB_NBYTES; i++) begin
                cfg_wk_reg[i] <= cfg_nv_reg[i];
            end
            loaded_reg <= 1'b1;
        end else begin
            if (rf_wr) begin
                cfg_wk_reg[rf_addr] <= rf_wdata;
            end
            if (host_wr && !host_wk_only && (link.addr[2:0] < `TCB_NBYTES)) begin
                cfg_wk_reg[link.addr[2:0]] <= link.wdata;
            end
            // Working-only writes touch just the volatile fields; the stored byte stays.
            if (host_wr && host_wk_only) begin
                unique case (link.addr[2:0])
                    `TCB_IDX_CFG0: cfg_wk_reg[`TCB_IDX_CFG0][`TCB_B_ARB] <=
                        link.wdata[`TCB_B_ARB];
                    `TCB_IDX_CFG2: cfg_wk_reg[`TCB_IDX_CFG2][`TCB_B_TUN:`TCB_B_EXT] <=
                        link.wdata[`TCB_B_TUN:`TCB_B_EXT];
                    `TCB_IDX_MASK0: cfg_wk_reg[`TCB_IDX_MASK0] <= link.wdata;
                    `TCB_IDX_MASK1: cfg_wk_reg[`TCB_IDX_MASK1] <= link.wdata;
                    default: ;
                endcase
            end
        end
    end

    // Link answer: one pulse per request, one cycle after it is seen.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            answered_reg <= 1'b0;
            link.ack <= 1'b0;
            link.nack <= 1'b0;
            link.rdata <= 8'h00;
        end else begin
            link.ack <= host_take && host_match;
            link.nack <= host_take && !host_match;
            if (!link.req) begin
                answered_reg <= 1'b0;
            end else if (host_take) begin
                answered_reg <= 1'b1;
            end
            if (host_take && host_match && !link.we) begin
                if (link.addr[2:0] >= `TCB_NBYTES) begin
                    link.rdata <= 8'h00;
                end else if (host_wk_only) begin
                    link.rdata <= cfg_wk_reg[link.addr[2:0]];
                end else begin
                    link.rdata <= cfg_nv_reg[link.addr[2:0]];
                end
            end
        end
    end

    // RF access answers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rf_ack <= 1'b0;
            rf_refused <= 1'b0;
            rf_rdata <= 8'h00;
            rf_auth_write_ok <= 1'b0;
        end else begin
            rf_ack <= rf_req && rf_ok;
            rf_refused <= rf_req && !rf_ok;
            rf_auth_write_ok <= rf_req && rf_ok && rf_we && (rf_kind != TCB_RF_CONFIG);
            if (rf_req && rf_ok && !rf_we && (rf_kind == TCB_RF_CONFIG)) begin
                rf_rdata <= (rf_addr < `TCB_NBYTES) ? cfg_wk_reg[rf_addr] : 8'h00;
            end
        end
    end

    // The supply is judged once per field entry, so a sagging supply later does not
    // silence a tag that is already talking.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            field_prev_reg <= 1'b0;
            below_latched_reg <= 1'b0;
            rf_off <= 1'b0;
        end else begin
            field_prev_reg <= field_present;
            if (field_present && !field_prev_reg) begin
                below_latched_reg <= supply_below;
            end
            rf_off <= cfg_wk_reg[`TCB_IDX_CFG0][`TCB_B_SILENT_EN] && below_latched_reg;
        end
    end

    always_comb begin
        sel_next = cfg_wk_reg[`TCB_IDX_SEL];
        sel_next[`TCB_B_CASCADE] = !cascade_level2;
        if (cascade_level2 && cfg_wk_reg[`TCB_IDX_CFG2][`TCB_B_SEL_INV]) begin
            sel_next[`TCB_B_SEL6] = !cfg_wk_reg[`TCB_IDX_SEL][`TCB_B_SEL6];
        end
        if (cfg_wk_reg[`TCB_IDX_CFG2][`TCB_B_TUN]) begin
            mode_next = TCB_MODE_TUNNEL;
        end else if (cfg_wk_reg[`TCB_IDX_CFG2][`TCB_B_EXT]) begin
            mode_next = TCB_MODE_EXTENDED;
        end else begin
            mode_next = TCB_MODE_STANDALONE;
        end
    end

    // Decoded outputs follow the working copy with one cycle of latency, except crc_check_en, which is held at 1.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sens_res_byte1 <= 8'h00;
            sel_res <= 8'h00;
            silent_threshold_code <= 3'h0;
            i2c_address <= 7'h00;
            crc_store <= 1'b0;
            crc_check_en <= 1'b0;
            payload_limit <= `TCB_PAYLOAD_FULL;
            aux_regulator_level <= 5'h00;
            aux_regulator_res <= 2'h0;
            mode <= TCB_MODE_STANDALONE;
            route_to_memory <= 1'b0;
            nak_on_error <= 1'b0;
            power_mode <= 2'h0;
            irq_mask_0 <= 8'h00;
            irq_mask_1 <= 8'h00;
        end else begin
            sens_res_byte1 <= cfg_wk_reg[`TCB_IDX_ANS];
            sel_res <= sel_next;
            silent_threshold_code <=
                cfg_wk_reg[`TCB_IDX_CFG0][`TCB_B_THR_HI:`TCB_B_THR_LO];
            i2c_address <= {`TCB_I2C_GROUP,
                cfg_wk_reg[`TCB_IDX_CFG0][`TCB_B_ADDR_HI:0]};
            crc_store <= cfg_wk_reg[`TCB_IDX_CFG1][`TCB_B_CRC_STORE]
                && (mode_next == TCB_MODE_TUNNEL);
            crc_check_en <= 1'b1;
            payload_limit <= (cfg_wk_reg[`TCB_IDX_CFG1][`TCB_B_CRC_STORE]
                && (mode_next == TCB_MODE_TUNNEL)) ? `TCB_PAYLOAD_CRC : `TCB_PAYLOAD_FULL;
            aux_regulator_level <=
                cfg_wk_reg[`TCB_IDX_CFG1][`TCB_B_VREG_HI:`TCB_B_VREG_LO];
            aux_regulator_res <= cfg_wk_reg[`TCB_IDX_CFG1][`TCB_B_RRES_HI:0];
            mode <= mode_next;
            route_to_memory <= (mode_next == TCB_MODE_STANDALONE);
            nak_on_error <= cfg_wk_reg[`TCB_IDX_CFG2][`TCB_B_NAK];
            power_mode <= cfg_wk_reg[`TCB_IDX_CFG2][`TCB_B_POW_HI:0];
            irq_mask_0 <= cfg_wk_reg[`TCB_IDX_MASK0];
            irq_mask_1 <= cfg_wk_reg[`TCB_IDX_MASK1];
        end
    end

    tcb_arbiter u_arbiter (
        .hclk(hclk),
        .hresetn(hresetn),
        .rf_priority(cfg_wk_reg[`TCB_IDX_CFG0][`TCB_B_ARB]),
        .rf_req(rf_mem_req && !rf_off),
        .host_req(host_mem_req),
        .rf_grant(rf_mem_grant),
        .host_grant(host_mem_grant)
    );
endmodule

// ---- rtl/tcb_host.sv ----
/*
 * Host controller end: takes byte transfer orders over AHB-Lite and carries
 * them out on the link to the tag.
 * Assumes a single AHB-Lite master, word transfers only, one tag on the link.
 */
`timescale 1ns/1ps
`include "tcb_consts.svh"
module tcb_host (
    input wire logic hclk,
    input wire logic hresetn,
    tcb_link_if.host link,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    import tcb_pkg::*;

    logic dp_write_reg;
    logic [7:0] dp_addr_reg;
    logic busy_reg;
    logic done_reg;
    logic nack_reg;
    tcb_byte_t rdata_reg;
    logic [2:0] target_reg;
    logic take;
    logic [31:0] status_word;

    assign take = hsel && hready && htrans[1];
    assign status_word = {16'h0000, rdata_reg, 5'h00, nack_reg, done_reg, busy_reg};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write_reg <= 1'b0;
            dp_addr_reg <= 8'h00;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
        end else begin
            hreadyout <= 1'b1;
            dp_write_reg <= take && hwrite;
            if (take) begin
                dp_addr_reg <= haddr[7:0];
            end
            // Read data is fetched in the address phase so the slave needs no wait state.
            if (take && !hwrite) begin
                unique case (haddr[7:0])
                    `TCB_HA_STATUS: hrdata <= status_word;
                    `TCB_HA_TARGET: hrdata <= {29'h00000000, target_reg};
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            target_reg <= 3'h0;
        end else if (dp_write_reg && (dp_addr_reg == `TCB_HA_TARGET)) begin
            target_reg <= hwdata[2:0];
        end
    end

    // An order written while a transfer is running is dropped; software polls busy.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            nack_reg <= 1'b0;
            rdata_reg <= 8'h00;
            link.req <= 1'b0;
            link.we <= 1'b0;
            link.dev_addr <= 7'h00;
            link.addr <= 4'h0;
            link.wdata <= 8'h00;
        end else if (busy_reg) begin
            if (link.ack || link.nack) begin
                link.req <= 1'b0;
                busy_reg <= 1'b0;
                done_reg <= 1'b1;
                nack_reg <= link.nack;
                if (link.ack && !link.we) begin
                    rdata_reg <= link.rdata;
                end
            end
        end else if (dp_write_reg && (dp_addr_reg == `TCB_HA_CTRL) && hwdata[0]) begin
            busy_reg <= 1'b1;
            done_reg <= 1'b0;
            nack_reg <= 1'b0;
            link.req <= 1'b1;
            link.we <= hwdata[1];
            link.dev_addr <= {`TCB_I2C_GROUP, target_reg};
            link.addr <= hwdata[11:8];
            link.wdata <= hwdata[23:16];
        end
    end
endmodule

// ---- verification/tcb_link_assertions.sv ----
/*
 * Protocol checker for the link between the host controller and the tag.
 * Assumes one clock, hclk, and the active-low reset hresetn.
 */
`timescale 1ns/1ps
module tcb_link_assertions (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic req,
    input wire logic we,
    input wire logic [6:0] dev_addr,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic ack,
    input wire logic nack,
    input wire logic [7:0] rdata
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_group_bits: assert property (req |-> dev_addr[6:3] == 4'hA)
        else $error("link device address group wrong");
    chk_answer_bound: assert property ($rose(req) |-> ##[1:6] (ack || nack))
        else $error("link request not answered in time");
    chk_answer_pulse: assert property ((ack || nack) |=> !(ack || nack))
        else $error("link answer longer than one cycle");
    chk_one_answer: assert property (!(ack && nack))
        else $error("link ack and nack together");
    chk_req_held: assert property ((req && !ack && !nack) |=>
        req && $stable(dev_addr) && $stable(addr) && $stable(wdata) && $stable(we))
        else $error("link request changed before answer");
    chk_req_released: assert property ((ack || nack) |=> !req)
        else $error("link request not released after answer");
    chk_answer_cause: assert property ((ack || nack) |-> $past(req))
        else $error("link answer without request");
    chk_write_rdata: assert property ((ack && we) |-> $stable(rdata))
        else $error("link read data moved on a write");

    cover property (ack && we);
    cover property (ack && !we);
    cover property (nack);
endmodule

// ---- verification/tag_config_byte_bank_tb_top.sv ----
/*
 * Self-checking bench: host end over AHB-Lite, tag user side driven here.
 * Assumes the design files, the link interface and the link checker.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("unexpected %s expected %h seen %h", n, e, g); end end
module tag_config_byte_bank_tb_top;
    import tcb_pkg::*;
    int failures = 0;
    int num_checks = 0;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic hsel = 1'h0, hwrite = 1'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, st;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, rf_ack, rf_refused, rf_off, crc_store, crc_chk, route, nak, awok;
    logic rf_req = 1'h0, rf_we = 1'h0, rf_auth = 1'h0, lvl2 = 1'h0;
    logic field = 1'h0, below = 1'h0, rmr = 1'h0, hmr = 1'h0, rgnt, hgnt;
    tcb_rf_kind_e rf_kind = TCB_RF_CONFIG;
    tcb_mode_e mode;
    logic [2:0] rf_addr = 3'h0, thr;
    logic [7:0] rf_wdata = 8'h00, rf_rdata, sens, sel, m0, m1, a, b4;
    logic [7:0] rnd = 8'h5D;
    logic [6:0] i2c;
    logic [5:0] plim;
    logic [4:0] vreg;
    logic [1:0] rres, powm;

    tcb_link_if link ();
    tcb_host tcb_host_i (.hclk(hclk), .hresetn(hresetn), .link(link), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
    tcb_device tcb_device_i (.hclk(hclk), .hresetn(hresetn), .link(link), .rf_req(rf_req),
        .rf_kind(rf_kind), .rf_we(rf_we), .rf_addr(rf_addr), .rf_wdata(rf_wdata),
        .rf_authenticated(rf_auth), .cascade_level2(lvl2), .field_present(field),
        .supply_below(below), .rf_mem_req(rmr), .host_mem_req(hmr), .rf_ack(rf_ack),
        .rf_refused(rf_refused), .rf_rdata(rf_rdata), .rf_auth_write_ok(awok),
        .sens_res_byte1(sens), .sel_res(sel), .rf_off(rf_off), .silent_threshold_code(thr),
        .i2c_address(i2c), .crc_store(crc_store), .crc_check_en(crc_chk),
        .payload_limit(plim), .aux_regulator_level(vreg), .aux_regulator_res(rres),
        .mode(mode), .route_to_memory(route), .nak_on_error(nak), .power_mode(powm),
        .irq_mask_0(m0), .irq_mask_1(m1), .rf_mem_grant(rgnt), .host_mem_grant(hgnt));
    tcb_link_assertions tcb_link_assertions_i (.hclk(hclk), .hresetn(hresetn),
        .req(link.req), .we(link.we), .dev_addr(link.dev_addr), .addr(link.addr),
        .wdata(link.wdata), .ack(link.ack), .nack(link.nack), .rdata(link.rdata));

    always #25 hclk = ~hclk;

    function automatic logic [7:0] lfsr(logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] exp_sel(logic [7:0] v, logic l2, logic inv);
        exp_sel = v;
        exp_sel[2] = !l2;
        exp_sel[6] = v[6] ^ (l2 & inv);
    endfunction
    function automatic tcb_mode_e exp_mode(logic [7:0] v);
        return v[6] ? TCB_MODE_TUNNEL : (v[5] ? TCB_MODE_EXTENDED : TCB_MODE_STANDALONE);
    endfunction

    task automatic print_verdict();
        if (failures == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic ahb(input logic w, input logic [31:0] ad, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= ad;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        r = hrdata;
    endtask

    // Polls status until the link transfer ends in done or nack.
    task automatic lnk(input logic w, input logic [3:0] la, input logic [7:0] d);
        int n;
        ahb(1'h1, 32'h0, {8'h00, d, 4'h0, la, 6'h00, w, 1'h1}, st);
        n = 0;
        do begin
            ahb(1'h0, 32'h4, 32'h0, st);
            n++;
        end while (st[2:1] == 2'h0 && n < 50);
    endtask

    // Decoded outputs are settled when this returns.
    task automatic rf(input tcb_rf_kind_e k, input logic w, input logic [2:0] ra,
                      input logic [7:0] d, input logic ok);
        @(posedge hclk);
        rf_req <= 1'h1;
        rf_kind <= k;
        rf_we <= w;
        rf_addr <= ra;
        rf_wdata <= d;
        @(posedge hclk);
        rf_req <= 1'h0;
        #1;
        `CHK("rf_ack", ok, rf_ack)
        `CHK("rf_refused", !ok, rf_refused)
        `CHK("rf_auth_write_ok", ok && w && (k != TCB_RF_CONFIG), awok)
        @(posedge hclk);
        #1;
    endtask

    initial begin
        repeat (40000) @(posedge hclk);
        failures++;
        print_verdict();
    end

    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'h1;
        repeat (3) @(posedge hclk);
        #1;
        `CHK("sens_res_byte1", 8'h44, sens)
        `CHK("sel_res", 8'h04, sel)
        `CHK("mode", TCB_MODE_STANDALONE, mode)
        `CHK("route_to_memory", 1'h1, route)
        `CHK("i2c_address", 7'h50, i2c)
        `CHK("crc_check_en", 1'h1, crc_chk)
        for (int i = 0; i < 7; i++) begin
            rnd = lfsr(rnd);
            a = (i == 2) ? (rnd & 8'hF8) : ((i == 4) ? (rnd | 8'h80) : rnd);
            lnk(1'h1, i[3:0], a);
            lnk(1'h0, i[3:0], 8'h00);
            `CHK("stored byte", {a, 8'h02}, st[15:0])
        end
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            a = rnd;
            b4 = {1'h1, i[1:0], a[4:0]};
            for (int k = 0; k < 7; k++) begin
                rf(TCB_RF_CONFIG, 1'h1, k[2:0], (k == 4) ? b4 : a, 1'h1);
            end
            rf(TCB_RF_CONFIG, 1'h0, 3'h3, 8'h00, 1'h1);
            `CHK("rf_rdata", a, rf_rdata)
            `CHK("sens_res_byte1", a, sens)
            `CHK("thr", a[6:4], thr)
            `CHK("i2c_address", {4'hA, a[2:0]}, i2c)
            `CHK("crc_store", a[7] & b4[6], crc_store)
            `CHK("payload_limit", (a[7] && b4[6]) ? 6'h1E : 6'h20, plim)
            `CHK("vreg", a[6:2], vreg)
            `CHK("rres", a[1:0], rres)
            `CHK("mode", exp_mode(b4), mode)
            `CHK("route_to_memory", b4[6:5] == 2'h0, route)
            `CHK("nak_on_error", b4[4], nak)
            `CHK("power_mode", b4[1:0], powm)
            `CHK("irq masks", {a, a}, {m0, m1})
            for (int l = 0; l < 2; l++) begin
                lvl2 <= l[0];
                repeat (2) @(posedge hclk);
                #1;
                `CHK("sel_res", exp_sel(a, l[0], b4[2]), sel)
            end
            lvl2 <= 1'h0;
        end
        for (int j = 0; j < 4; j++) begin
            rf(TCB_RF_CONFIG, 1'h1, 3'h4, {4'h8, j[1], 3'h0}, 1'h1);
            rf_auth <= j[0];
            rf(TCB_RF_AUTH_SETTING, 1'h1, 3'h0, 8'h00, j[1] & j[0]);
            rf(TCB_RF_PASSWORD, 1'h1, 3'h0, 8'h00, j[0]);
        end
        rf(TCB_RF_CONFIG, 1'h1, 3'h2, 8'h80, 1'h1);
        below <= 1'h1;
        field <= 1'h1;
        repeat (3) @(posedge hclk);
        #1;
        `CHK("rf_off", 1'h1, rf_off)
        below <= 1'h0;
        repeat (3) @(posedge hclk);
        #1;
        `CHK("rf_off", 1'h1, rf_off)
        rf(TCB_RF_CONFIG, 1'h0, 3'h0, 8'h00, 1'h0);
        field <= 1'h0;
        repeat (2) @(posedge hclk);
        field <= 1'h1;
        repeat (3) @(posedge hclk);
        #1;
        `CHK("rf_off", 1'h0, rf_off)
        hmr <= 1'h1;
        repeat (2) @(posedge hclk);
        rmr <= 1'h1;
        repeat (3) @(posedge hclk);
        #1;
        `CHK("grants", 2'h1, {rgnt, hgnt})
        lnk(1'h1, 4'hA, 8'h08);
        repeat (2) @(posedge hclk);
        #1;
        `CHK("grants", 2'h2, {rgnt, hgnt})
        rmr <= 1'h0;
        hmr <= 1'h0;
        for (int k = 0; k < 4; k++) begin
            lnk(1'h1, 4'hC, {1'h0, k[1:0], 5'h00});
            repeat (2) @(posedge hclk);
            #1;
            `CHK("mode", exp_mode({1'h0, k[1:0], 5'h00}), mode)
        end
        rf(TCB_RF_CONFIG, 1'h1, 3'h2, 8'h05, 1'h1);
        lnk(1'h0, 4'h0, 8'h00);
        `CHK("nack", 1'h1, st[2])
        ahb(1'h1, 32'h8, 32'h5, st);
        ahb(1'h0, 32'h8, 32'h0, st);
        `CHK("target", 3'h5, st[2:0])
        ahb(1'h0, 32'h10, 32'h0, st);
        `CHK("unmapped", 32'h0, st)
        `CHK("hresp", 1'h0, hresp)
        rf(TCB_RF_CONFIG, 1'h1, 3'h4, 8'h00, 1'h1);
        rf(TCB_RF_CONFIG, 1'h1, 3'h0, 8'h11, 1'h0);
        lnk(1'h0, 4'h4, 8'h00);
        `CHK("host access", 2'h1, st[2:1])
        print_verdict();
    end
endmodule
